// ==== rtl/fault_status_irq_mask.v ====
// fault status collection, interrupt masking and led switch dead-time control
`timescale 1ns/1ns
`default_nettype none
`include "fault_status_irq_mask_defs.vh"
// What this block does
// RULE1: status bit 7 high on any low-voltage supply good failure or overvoltage, else low.
// RULE2: status bit 6 follows light source fault level; maskable by mask bit 6.
// RULE3: status bit 5 is the power request input inverted; maskable source.
// RULE4: status bit 4 follows mirror array fault level; maskable by mask bit 4.
// RULE5: status bit 3 high while input supply is below lockout threshold.
// RULE6: status bit 2 high while input supply is below low warning threshold.
// RULE7: bit 1 sets above 156.5C or rail fault; clears below 132.5C without fault.
// RULE8: bit 0 sets above 123.4C, clears below 121.4C, holds between.
// RULE9: mask bit shares its source's position; one blocks, zero passes the interrupt.
// RULE10: mask register resets to f5, leaving lockout and overheat stop unmasked.
// RULE11: dead-time code steps 111 ns; 0 none, 1 is 333 ns, 255 is 28527 ns.
// RULE12: dead-time register is read/write and resets to 00.
// RULE13: interrupt output high while an unmasked status bit is set.
// RULE14: programmed dead time separates one channel switch off and the next on.

module fault_status_irq_mask
#(
  parameter [15:0] step_ns = `BBM_STEP_NS
)
(
  // clock and reset
  input  wire       clk_sys,
  input  wire       nrst,
  // register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_q,
  // interrupt
  output reg        irq_q,
  // fault and monitor pins
  input  wire       supply_pg_fail,
  input  wire       supply_ov_fail,
  input  wire       light_source_fail,
  input  wire       power_request_in,
  input  wire       mirror_array_fail,
  input  wire       vin_below_lockout_threshold,
  input  wire       vin_below_low_vin_threshold,
  input  wire       temp_above_stop_set,
  input  wire       temp_below_stop_release,
  input  wire       internal_five_volt_rail_fault,
  input  wire       temp_above_alert_set,
  input  wire       temp_below_alert_release,
  // led channel selection and switch drives
  // the request is a pin as well and passes the same filter as the faults
  input  wire [1:0] channel_request,
  output reg  [2:0] channel_switch_on_q
);

  // switch sequencer states
  // on: one switch (or none) is made and the request is watched
  // gap: every switch is broken while the dead time runs out
  localparam [1:0] ST_ON   = 2'b00;
  localparam [1:0] ST_GAP  = 2'b01;

  // raw pin vector fed to the synchronisers
  // every pin comes from the analog side or another clock, so all of them
  // pass the same filter before any logic looks at them
  wire [`RAW_WIDTH-1:0] raw_in;
  wire [`RAW_WIDTH-1:0] pin_level;

  assign raw_in[`RAW_PG_FAIL]       = supply_pg_fail;
  assign raw_in[`RAW_OV_FAIL]       = supply_ov_fail;
  assign raw_in[`RAW_LIGHT_FAIL]    = light_source_fail;
  assign raw_in[`RAW_POWER_REQ]     = power_request_in;
  assign raw_in[`RAW_MIRROR_FAIL]   = mirror_array_fail;
  assign raw_in[`RAW_VIN_LOCKOUT]   = vin_below_lockout_threshold;
  assign raw_in[`RAW_VIN_LOW]       = vin_below_low_vin_threshold;
  assign raw_in[`RAW_TEMP_STOP_HI]  = temp_above_stop_set;
  assign raw_in[`RAW_TEMP_STOP_LO]  = temp_below_stop_release;
  assign raw_in[`RAW_RAIL_FAULT]    = internal_five_volt_rail_fault;
  assign raw_in[`RAW_TEMP_ALERT_HI] = temp_above_alert_set;
  assign raw_in[`RAW_TEMP_ALERT_LO] = temp_below_alert_release;
  assign raw_in[`RAW_CH_REQ_MSB:`RAW_CH_REQ_LSB] = channel_request;

  // three-stage synchroniser per pin; a level counts once stages two and three agree
  // only the second stage reads the first, so a metastable first stage never
  // reaches the status word; a pulse shorter than two cycles never gets through,
  // which keeps comparator chatter out of the status bits
  genvar gi;
  generate
    for (gi = 0; gi < `RAW_WIDTH; gi = gi + 1)
    begin : g_sync
      reg meta_q;
      reg stage2_q;
      reg stage3_q;
      reg level_q;

      always @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_q   <= 1'b0;
          stage2_q <= 1'b0;
          stage3_q <= 1'b0;
          level_q  <= 1'b0;
        end
        else
        begin
          meta_q   <= raw_in[gi];
          stage2_q <= meta_q;
          stage3_q <= stage2_q;
          if (stage2_q == stage3_q)
            level_q <= stage3_q;
        end
      end

      assign pin_level[gi] = level_q;
    end
  endgenerate

  // registers
  // mask and dead time are software state, status and pending follow the pins
  reg [7:0]  status_q;
  reg [7:0]  status_d;
  reg [7:0]  mask_q;
  reg [7:0]  dead_code_q;
  reg [7:0]  pending_q;
  reg        stop_hold_q;
  reg        alert_hold_q;

  // hysteresis and rail terms for the two thermal flags
  // each temperature band arrives as two comparator pins, one above the set
  // point and one below the release point; between them neither is high
  wire stop_set   = pin_level[`RAW_TEMP_STOP_HI] | pin_level[`RAW_RAIL_FAULT];
  wire stop_clr   = pin_level[`RAW_TEMP_STOP_LO] & ~pin_level[`RAW_RAIL_FAULT];
  wire alert_set  = pin_level[`RAW_TEMP_ALERT_HI];
  wire alert_clr  = pin_level[`RAW_TEMP_ALERT_LO];

  // thermal flags hold their value inside the hysteresis band
  // the set term is tested first, so a set and a release seen together
  // leave the flag high; a rail fault also blocks the release of the stop flag
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      stop_hold_q  <= 1'b0;
      alert_hold_q <= 1'b0;
    end
    else
    begin
      if (stop_set)
        stop_hold_q <= 1'b1;                   // [RULE7]
      else if (stop_clr)
        stop_hold_q <= 1'b0;                   // [RULE7]
      if (alert_set)
        alert_hold_q <= 1'b1;                  // [RULE8]
      else if (alert_clr)
        alert_hold_q <= 1'b0;                  // [RULE8]
    end
  end

  // live status word assembled from the filtered pins
  // bits 7 to 2 follow their pins, bits 1 and 0 come from the hysteresis flags
  always @*
  begin
    status_d = `STATUS_RESET;
    status_d[`BIT_SUPPLY_FAIL]    = pin_level[`RAW_PG_FAIL] | pin_level[`RAW_OV_FAIL]; // [RULE1]
    status_d[`BIT_LIGHT_FAIL]     = pin_level[`RAW_LIGHT_FAIL];                        // [RULE2]
    status_d[`BIT_POWER_REQ]      = ~pin_level[`RAW_POWER_REQ];                        // [RULE3]
    status_d[`BIT_MIRROR_FAIL]    = pin_level[`RAW_MIRROR_FAIL];                       // [RULE4]
    status_d[`BIT_VIN_LOCKOUT]    = pin_level[`RAW_VIN_LOCKOUT];                       // [RULE5]
    status_d[`BIT_VIN_LOW]        = pin_level[`RAW_VIN_LOW];                           // [RULE6]
    status_d[`BIT_OVERHEAT_STOP]  = stop_hold_q;                                       // [RULE7]
    status_d[`BIT_OVERHEAT_ALERT] = alert_hold_q;                                      // [RULE8]
  end

  // register decode
  // writes to the status and pending offsets have no decode and are dropped;
  // only mask and dead time can be written
  wire wr_mask    = reg_wr && (reg_addr == `ADDR_SOURCE_MASK);
  wire wr_dead    = reg_wr && (reg_addr == `ADDR_DEAD_TIME);
  wire rd_pending = reg_rd && (reg_addr == `ADDR_IRQ_PENDING);

  // a status bit that rises latches into pending; a new rise beats a clearing read
  // pending keeps a short fault visible after the pin has gone back,
  // so software never misses an event that ended before it looked;
  // a read of pending clears the bits it returned, but not a rise of the same cycle
  wire [7:0] rise = status_d & ~status_q;

  // status, mask, dead-time and pending registers
  // status_q is one cycle behind status_d and serves as the edge reference
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      status_q    <= `STATUS_RESET;
      mask_q      <= `MASK_RESET;                // [RULE10]
      dead_code_q <= `DEAD_TIME_RESET;           // [RULE12]
      pending_q   <= `STATUS_RESET;
    end
    else
    begin
      status_q <= status_d;
      if (wr_mask)
        mask_q <= reg_wdata;                     // [RULE9]
      if (wr_dead)
        dead_code_q <= reg_wdata;                // [RULE12]
      if (rd_pending)
        pending_q <= rise;
      else
        pending_q <= pending_q | rise;
    end
  end

  // read data stands only in the cycle after the read strobe
  // the port is idle at zero otherwise, so an unmapped read returns zero
  // and the bus never needs a wait state
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      reg_rdata_q <= `READ_IDLE;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_FAULT_STATUS: reg_rdata_q <= status_q;
        `ADDR_SOURCE_MASK:  reg_rdata_q <= mask_q;
        `ADDR_DEAD_TIME:    reg_rdata_q <= dead_code_q;  // [RULE12]
        `ADDR_IRQ_PENDING:  reg_rdata_q <= pending_q;
        default:            reg_rdata_q <= `READ_IDLE;
      endcase
    end
    else
      reg_rdata_q <= `READ_IDLE;
  end

  // interrupt: any unmasked live or latched source, one in the mask blocks it
  // the next status word and the rise term are used so the output leads the
  // status readback by one cycle; masking a source takes effect at the next edge
  // and unmasking a still pending source raises the line again
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      irq_q <= 1'b0;
    else
      irq_q <= |((status_d | pending_q | rise) & ~mask_q);  // [RULE9] [RULE13]
  end

  // dead time in ns: (code + 2) steps, zero for code 0
  // the largest code gives 257 steps, which still fits the 16-bit width
  // at the full step size; the product is kept at 16 bits on purpose
  // code 0 still breaks every switch for one cycle before the next is made
  wire [15:0] code_wide  = {8'h00, dead_code_q};
  wire [15:0] steps      = code_wide + `BBM_BASE_STEPS;
  wire [15:0] dead_ns    = (dead_code_q == `DEAD_CODE_ZERO) ? `NS_ZERO
                           : steps * step_ns;                 // [RULE11]

  // decode a channel request into one-hot switch drives; 0 selects none
  // one-hot by construction, so two channels can never be made at once
  function [2:0] switch_decode;
    input [1:0] req;
    begin
      case (req)
        2'b01:   switch_decode = 3'b001;
        2'b10:   switch_decode = 3'b010;
        2'b11:   switch_decode = 3'b100;
        default: switch_decode = 3'b000;
      endcase
    end
  endfunction

  // switch sequencer registers
  // elapsed time is counted in ns, one clock period per cycle, and compared
  // with the target taken when the gap began
  reg [1:0]  sw_state_q;
  reg [1:0]  active_req_q;
  reg [15:0] elapsed_ns_q;
  reg [15:0] target_ns_q;

  wire [1:0] req_level = pin_level[`RAW_CH_REQ_MSB:`RAW_CH_REQ_LSB];
  wire       gap_done  = (elapsed_ns_q >= target_ns_q);

  // break all switches, wait the dead time, then make the new channel
  // a request that changes during the gap only picks the channel made at its end;
  // the gap is not restarted, so a chattering request cannot stall the switches
  // the dead code is read once, when the gap begins; a write during a gap
  // takes effect at the next channel change
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sw_state_q          <= ST_ON;
      active_req_q        <= 2'b00;
      elapsed_ns_q        <= `NS_ZERO;
      target_ns_q         <= `NS_ZERO;
      channel_switch_on_q <= 3'b000;
    end
    else
    begin
      case (sw_state_q)
        ST_ON:
        begin
          if (req_level != active_req_q)
          begin
            channel_switch_on_q <= 3'b000;       // [RULE14]
            elapsed_ns_q        <= `NS_ZERO;
            target_ns_q         <= dead_ns;      // [RULE11] [RULE14]
            sw_state_q          <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          // the channel made at the end follows late request changes
          if (gap_done)
          begin
            active_req_q        <= req_level;
            channel_switch_on_q <= switch_decode(req_level);  // [RULE14]
            sw_state_q          <= ST_ON;
          end
          else
            elapsed_ns_q <= elapsed_ns_q + `CLK_PERIOD_NS;
        end
        default:
        begin
          channel_switch_on_q <= 3'b000;
          sw_state_q          <= ST_ON;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== include/fault_status_irq_mask_defs.vh ====
// constants for the fault status, interrupt mask and switch dead-time block
`ifndef FAULT_STATUS_IRQ_MASK_DEFS_VH
`define FAULT_STATUS_IRQ_MASK_DEFS_VH

// register offsets on the 8-bit register port
`define ADDR_FAULT_STATUS   8'h0c
`define ADDR_SOURCE_MASK    8'h0d
`define ADDR_DEAD_TIME      8'h0e
`define ADDR_IRQ_PENDING    8'h20

// reset values
`define MASK_RESET          8'hf5
`define DEAD_TIME_RESET     8'h00
`define STATUS_RESET        8'h00
`define READ_IDLE           8'h00

// status, mask and pending bit positions
`define BIT_SUPPLY_FAIL     7
`define BIT_LIGHT_FAIL      6
`define BIT_POWER_REQ       5
`define BIT_MIRROR_FAIL     4
`define BIT_VIN_LOCKOUT     3
`define BIT_VIN_LOW         2
`define BIT_OVERHEAT_STOP   1
`define BIT_OVERHEAT_ALERT  0

// positions of the raw pin inputs in the synchroniser vector
`define RAW_PG_FAIL         0
`define RAW_OV_FAIL         1
`define RAW_LIGHT_FAIL      2
`define RAW_POWER_REQ       3
`define RAW_MIRROR_FAIL     4
`define RAW_VIN_LOCKOUT     5
`define RAW_VIN_LOW         6
`define RAW_TEMP_STOP_HI    7
`define RAW_TEMP_STOP_LO    8
`define RAW_RAIL_FAULT      9
`define RAW_TEMP_ALERT_HI   10
`define RAW_TEMP_ALERT_LO   11
`define RAW_CH_REQ_LSB      12
`define RAW_CH_REQ_MSB      13
`define RAW_WIDTH           14

// dead-time timing: code n gives (n + 2) steps, code 0 gives none
`define BBM_STEP_NS         16'd111
`define BBM_BASE_STEPS      16'd2
`define CLK_PERIOD_NS       16'd4
`define DEAD_CODE_ZERO      8'h00
`define NS_ZERO             16'h0000

`endif

// ==== bench/fault_status_irq_mask_properties.sv ====
// port assertions for the fault status, mask and dead-time block
`timescale 1ns/1ns
`default_nettype none
`include "fault_status_irq_mask_defs.vh"
module fault_status_irq_mask_properties
(
  // clock, reset and register port
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // pins and switch drives
  input wire logic       power_request_in,
  input wire logic       mirror_array_fail,
  input wire logic [2:0] channel_switch_on_q
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // decoded strobes keep the properties short
  wire logic wr_mask = reg_wr && reg_addr == `ADDR_SOURCE_MASK;
  wire logic rd_mask = reg_rd && reg_addr == `ADDR_SOURCE_MASK;
  wire logic wr_dead = reg_wr && reg_addr == `ADDR_DEAD_TIME;
  wire logic rd_dead = reg_rd && reg_addr == `ADDR_DEAD_TIME;
  wire logic rd_stat = reg_rd && reg_addr == `ADDR_FAULT_STATUS;

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
    else $error("read data not idle");
  mask_rw_a: assert property (wr_mask ##1 rd_mask |=> reg_rdata_q == $past(reg_wdata, 2))
    else $error("mask readback wrong");
  dead_rw_a: assert property (wr_dead ##1 rd_dead |=> reg_rdata_q == $past(reg_wdata, 2))
    else $error("dead time readback wrong");
  unmapped_a: assert property (reg_rd && reg_addr == 8'h3f |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  switch_onehot_a: assert property ($onehot0(channel_switch_on_q))
    else $error("two switches on");
  bbm_gap_a: assert property (channel_switch_on_q != 3'h0 && $past(channel_switch_on_q) != 3'h0
    |-> $stable(channel_switch_on_q))
    else $error("switch made before break");
  req_bit_a: assert property ($stable(power_request_in)[*8] ##0 rd_stat
    |=> reg_rdata_q[`BIT_POWER_REQ] == !$past(power_request_in, 2))
    else $error("power request bit wrong");
  mirror_bit_a: assert property ($stable(mirror_array_fail)[*8] ##0 rd_stat
    |=> reg_rdata_q[`BIT_MIRROR_FAIL] == $past(mirror_array_fail, 2))
    else $error("mirror fault bit wrong");
endmodule

bind fault_status_irq_mask fault_status_irq_mask_properties u_props
(
  .clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
  .power_request_in, .mirror_array_fail, .channel_switch_on_q
);
`default_nettype wire

// ==== bench/tb_fault_status_irq_mask.sv ====
// self-checking bench for the fault status, mask and dead-time block
`timescale 1ns/1ns
`default_nettype none
`include "fault_status_irq_mask_defs.vh"
module tb_fault_status_irq_mask;
  localparam int STEP = 4;
  logic        clk_sys;
  logic        nrst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata_q;
  logic        irq_q;
  logic [11:0] p;
  logic [1:0]  chan;
  logic [2:0]  sw;
  int          error_cnt;
  int          checked;
  int          cycles;
  // pin vector and expected status per step
  logic [19:0] st_tab [16] = '{20'h90800, 20'h90980, 20'h90a80, 20'h90c40, 20'h90020, 20'h91810,
    20'h92808, 20'h94804, 20'h88802, 20'h80802, 20'h90800, 20'ha0802, 20'h90800, 20'h50801,
    20'h10801, 20'h90800};
  logic [7:0]  codes [4] = '{8'h00, 8'h01, 8'h05, 8'hff};

  fault_status_irq_mask #(.step_ns(16'h0004)) u_dut
  (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q),
    .supply_pg_fail(p[0]), .supply_ov_fail(p[1]), .light_source_fail(p[2]),
    .power_request_in(p[3]), .mirror_array_fail(p[4]), .vin_below_lockout_threshold(p[5]),
    .vin_below_low_vin_threshold(p[6]), .temp_above_stop_set(p[7]), .temp_below_stop_release(p[8]),
    .internal_five_volt_rail_fault(p[9]), .temp_above_alert_set(p[10]),
    .temp_below_alert_release(p[11]), .channel_request(chan), .channel_switch_on_q(sw)
  );

  // clock and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      end_of_test;
    end
  end

  task chk(input [63:0] nm, input [15:0] e, input [15:0] s);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %0s exp %h got %h", nm, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [7:0] a, output [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata_q;
    @(posedge clk_sys);
  endtask
  task rdc(input [7:0] a, input [7:0] e, input [63:0] nm);
    logic [7:0] d;
    rd(a, d);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask
  task irqc(input logic e);
    cyc(8);
    @(negedge clk_sys);
    chk("irq", {15'h0000, e}, {15'h0000, irq_q});
    @(posedge clk_sys);
  endtask

  task t_reset;
    rdc(`ADDR_SOURCE_MASK, 8'hf5, "mask");
    rdc(`ADDR_DEAD_TIME, 8'h00, "dead");
    rdc(8'h3f, 8'h00, "unmapped");
    wr(`ADDR_DEAD_TIME, 8'ha5);
    rdc(`ADDR_DEAD_TIME, 8'ha5, "dead");
    wr(`ADDR_SOURCE_MASK, 8'h5a);
    rdc(`ADDR_SOURCE_MASK, 8'h5a, "mask");
    wr(`ADDR_SOURCE_MASK, 8'hf5);
    $display("t_reset done");
  endtask
  // each source alone, then the two hysteresis bands
  task t_status;
    for (int i = 0; i < 16; i++)
    begin
      p <= st_tab[i][19:8];
      cyc(8);
      rdc(`ADDR_FAULT_STATUS, st_tab[i][7:0], "status");
    end
    $display("t_status done");
  endtask
  task t_irq;
    logic [7:0] d;
    rd(`ADDR_IRQ_PENDING, d);
    irqc(1'b0);
    p <= 12'h928;
    irqc(1'b1);
    wr(`ADDR_SOURCE_MASK, 8'hff);
    irqc(1'b0);
    p <= 12'h90c;
    wr(`ADDR_SOURCE_MASK, 8'hbf);
    irqc(1'b1);
    p <= 12'h908;
    cyc(8);
    rd(`ADDR_IRQ_PENDING, d);
    irqc(1'b0);
    wr(`ADDR_SOURCE_MASK, 8'hf5);
    $display("t_irq done");
  endtask
  // gap of switches off between channels follows the code
  task t_bbm;
    int n;
    int e;
    chan <= 2'h1;
    cyc(300);
    for (int i = 0; i < 4; i++)
    begin
      wr(`ADDR_DEAD_TIME, codes[i]);
      chan <= 2'(((i + 1) % 3) + 1);
      e = (codes[i] == 8'h00) ? 1 : ((codes[i] + 2) * STEP + 3) / 4 + 1;
      n = 0;
      while (sw != 3'h0 && n < 50)
      begin
        @(negedge clk_sys);
        n++;
      end
      n = 0;
      while (sw === 3'h0 && n < 400)
      begin
        @(negedge clk_sys);
        n++;
      end
      chk("gap", 16'(e), 16'(n));
      chk("switch", 16'(1 << ((i + 1) % 3)), {13'h0000, sw});
      @(posedge clk_sys);
    end
    $display("t_bbm done");
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    p = 12'h908;
    chan = 2'h0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_status;
    t_irq;
    t_bbm;
    end_of_test;
  end
endmodule
`default_nettype wire
